// File: hw/chc_pkg.sv
package chc_pkg;

  localparam logic [4:0] HDR_OCTETS = 5'h14;
  localparam int HDR_BITS = 160;
  localparam int ADDR_BITS = 64;
  localparam int VALUE_BITS = 60;
  localparam int OCTET_BITS = 8;

  localparam logic [3:0] FMT_16 = 4'h4;
  localparam logic [3:0] FMT_48 = 4'h8;
  localparam logic [3:0] FMT_60_PUB_IND = 4'hC;
  localparam logic [1:0] FMT_60_PREFIX = 2'h3;
  localparam int FMT_GROUP_POS = 1;

  localparam int A16_IG = 15;
  localparam int A48_IG = 47;
  localparam int A48_UL = 46;
  localparam logic [3:0] BCD_MAX_DIGITS = 4'hF;

  localparam logic [5:0] PID_LLC = 6'h01;
  localparam logic [5:0] PID_LOCAL_LO = 6'h30;
  localparam logic [2:0] EXT_MAX = 3'h5;
  localparam logic [1:0] PAD_ROUND = 2'h3;
  localparam logic [2:0] CRC_OCTETS = 3'h4;
  localparam logic [15:0] BRIDGING_TX = 16'h0000;

  localparam logic [4:0] OCT_SRC_FIRST = 5'h09;
  localparam logic [4:0] OCT_PIPL = 5'h11;
  localparam logic [4:0] OCT_QCE = 5'h12;
  localparam logic [4:0] OCT_BRIDGE = 5'h13;

  typedef struct packed {
    logic [63:0] dest;
    logic [63:0] src;
    logic [5:0] protocol_id;
    logic [1:0] pad_count_field;
    logic [2:0] access_urgency_field;
    logic discard_pref_bit;
    logic checksum_present_bit;
    logic [2:0] extension_size_field;
    logic [15:0] bridging;
  } chc_hdr_s;

  typedef struct packed {
    logic [3:0] dest_fmt;
    logic [59:0] dest_value;
    logic [3:0] dest_digits;
    logic [59:0] src_value;
    logic [3:0] src_digits;
    logic [5:0] protocol_id;
    logic [13:0] payload_len;
    logic [2:0] priority_level;
    logic checksum_present;
    logic [2:0] extension_size;
  } chc_tx_req_s;

  typedef struct packed {
    logic [3:0] fmt;
    logic group;
    logic broadcast;
    logic local_admin;
    logic reserved;
  } chc_addr_info_s;

  typedef struct packed {
    chc_addr_info_s dest;
    chc_addr_info_s src;
    logic [59:0] destination_field;
    logic [59:0] origin_field;
    logic [5:0] protocol_id;
    logic pid_llc;
    logic pid_local;
    logic [1:0] pad_count_field;
    logic [2:0] access_urgency_field;
    logic discard_pref_bit;
    logic checksum_present_bit;
    logic [2:0] extension_size_field;
    logic [4:0] ext_octets;
    logic [2:0] check_octets;
  } chc_rx_hdr_s;

  typedef struct packed {
    logic src_group;
    logic fmt_reserved;
    logic fmt_mismatch;
    logic pid_reserved;
    logic ext_invalid;
  } chc_rx_err_s;

  function automatic logic fmt_is_reserved(input logic [3:0] fmt);
    return !(fmt == FMT_16 || fmt == FMT_48 || fmt[3:2] == FMT_60_PREFIX);
  endfunction : fmt_is_reserved

  function automatic logic [1:0] pad_of(input logic [13:0] len);
    return 2'(PAD_ROUND - 2'(len[1:0] + PAD_ROUND));
  endfunction : pad_of

endpackage : chc_pkg

// File: hw/chc_addr_build.sv
`timescale 1ns/1ps
`default_nettype none
module chc_addr_build import chc_pkg::*; (
  input wire logic [3:0] fmt,
  input wire logic [59:0] value,
  input wire logic [3:0] digits,
  input wire logic force_individual,
  output logic [63:0] field
);
  logic [3:0] fmt_out;
  logic [3:0] unused_digits;
  logic [5:0] shift;
  logic [59:0] v;

  always_comb begin
    fmt_out = fmt;
    v = '0;
    unused_digits = (digits == 4'h0 || digits > BCD_MAX_DIGITS) ? 4'h0 : 4'(BCD_MAX_DIGITS - digits);
    shift = {unused_digits, 2'b00};
    if (fmt == FMT_16) begin
      v[A16_IG:0] = value[A16_IG:0];
      v[A16_IG] = value[A16_IG] & !force_individual;
    end else if (fmt == FMT_48) begin
      v[A48_IG:0] = value[A48_IG:0];
      v[A48_IG] = value[A48_IG] & !force_individual;
    end else begin
      if (force_individual) begin
        fmt_out[FMT_GROUP_POS] = 1'b0;
      end
      v = value;
      if (fmt_out == FMT_60_PUB_IND) begin
        v = (value << shift) | ~({VALUE_BITS{1'b1}} << shift);
      end
    end
    field = {fmt_out, v};
  end
endmodule : chc_addr_build
`default_nettype wire

// File: hw/chc_addr_check.sv
`timescale 1ns/1ps
`default_nettype none
module chc_addr_check import chc_pkg::*; (
  input wire logic [63:0] field,
  output chc_addr_info_s info
);
  always_comb begin
    info = '0;
    info.fmt = field[ADDR_BITS-1:VALUE_BITS];
    info.reserved = fmt_is_reserved(info.fmt);
    if (info.fmt == FMT_16) begin
      info.group = field[A16_IG];
      info.broadcast = &field[A16_IG:0];
      info.local_admin = 1'b1;
    end else if (info.fmt == FMT_48) begin
      info.group = field[A48_IG];
      info.broadcast = &field[A48_IG:0];
      info.local_admin = field[A48_UL];
    end else if (!info.reserved) begin
      info.group = info.fmt[FMT_GROUP_POS];
    end
  end
endmodule : chc_addr_check
`default_nettype wire

// File: hw/chc_header_codec.sv
// Functional notes
// - address top bit: 0 individual, 1 group
// - all-ones 16/48-bit group means broadcast
// - 48-bit second bit: universal 0, local 1
// - short public number padded right with ones; sent padded only in format 1100, not in 1110
// - bcd digits, most significant digit first
// - origin never group, same format as destination; a 111x destination gives a 110x origin (group bit cleared)
// - protocol id upper six, pad count lower two
// - id 1 llc, 48-63 local, rest reserved
// - pad count is 3 minus (len+3) mod 4
// - urgency, discard, checksum, extension size layout
// - urgency code equals requested priority
// - discard preference bit always sent zero
// - checksum bit tells four trailing check octets
// - extension octets are four times size field
// - extension sizes 6, 7 never sent, flagged
// - bridging octets sent as zero
// - 64-bit address: format, zero pad, address
// - format codes 0100, 1000, 11xx; others reserved
// - padding between format and address zero
`timescale 1ns/1ps
`default_nettype none
module chc_header_codec import chc_pkg::*; (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic tx_start,
  input wire chc_tx_req_s tx_req,
  output logic tx_ready,
  output logic tx_refused,
  output logic [7:0] tx_octet,
  output logic tx_octet_valid,
  output logic tx_octet_last,
  input wire logic [7:0] rx_octet,
  input wire logic rx_octet_valid,
  input wire logic rx_octet_first,
  output chc_rx_hdr_s rx_hdr,
  output chc_rx_err_s rx_err,
  output logic rx_done
);

  typedef enum logic [1:0] {
    CHC_TX_IDLE = 2'b00,
    CHC_TX_SEND = 2'b01
  } chc_tx_state_e;

  typedef enum logic [1:0] {
    CHC_RX_IDLE = 2'b00,
    CHC_RX_COLLECT = 2'b01
  } chc_rx_state_e;

  chc_tx_state_e tx_state;
  chc_rx_state_e rx_state;
  chc_hdr_s next_hdr;
  chc_hdr_s rx_raw;
  chc_addr_info_s rx_dest_info;
  chc_addr_info_s rx_src_info;
  chc_rx_hdr_s next_rx_hdr;
  chc_rx_err_s next_rx_err;
  logic [63:0] dest_field;
  logic [63:0] src_field;
  logic [HDR_BITS-1:0] tx_shift;
  logic [HDR_BITS-OCTET_BITS-1:0] rx_shift;
  logic [4:0] tx_count;
  logic [4:0] rx_count;
  logic [13:0] tx_len_q;
  logic tx_ok;
  logic start_taken;
  logic tx_end;
  logic rx_last;

  chc_addr_build u_dest_build (
    .fmt(tx_req.dest_fmt),
    .value(tx_req.dest_value),
    .digits(tx_req.dest_digits),
    .force_individual(1'b0),
    .field(dest_field)
  );

  // origin takes the destination format with its group bit cleared, never group
  chc_addr_build u_src_build (
    .fmt(tx_req.dest_fmt),
    .value(tx_req.src_value),
    .digits(tx_req.src_digits),
    .force_individual(1'b1),
    .field(src_field)
  );

  chc_addr_check u_dest_check (
    .field(rx_raw.dest),
    .info(rx_dest_info)
  );

  chc_addr_check u_src_check (
    .field(rx_raw.src),
    .info(rx_src_info)
  );

  // refuse what cannot be sent legally
  assign tx_ok = !fmt_is_reserved(tx_req.dest_fmt) && tx_req.extension_size <= EXT_MAX;
  assign start_taken = tx_start && tx_state == CHC_TX_IDLE && tx_ok;
  assign tx_end = tx_state == CHC_TX_SEND && tx_count == HDR_OCTETS;

  always_comb begin
    next_hdr = '0;
    next_hdr.dest = dest_field;
    next_hdr.src = src_field;
    // id passed as given, reserved ids allowed on send
    next_hdr.protocol_id = tx_req.protocol_id;
    next_hdr.pad_count_field = pad_of(tx_req.payload_len);
    next_hdr.access_urgency_field = tx_req.priority_level;
    next_hdr.discard_pref_bit = 1'b0;
    next_hdr.checksum_present_bit = tx_req.checksum_present;
    next_hdr.extension_size_field = tx_req.extension_size;
    next_hdr.bridging = BRIDGING_TX;
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      tx_state <= CHC_TX_IDLE;
      tx_count <= 5'h00;
    end else begin
      unique case (tx_state)
        CHC_TX_IDLE: begin
          if (start_taken) begin
            tx_state <= CHC_TX_SEND;
            tx_count <= 5'h01;
          end
        end
        CHC_TX_SEND: begin
          if (tx_end) begin
            tx_state <= CHC_TX_IDLE;
            tx_count <= 5'h00;
          end else begin
            tx_count <= 5'(tx_count + 5'h01);
          end
        end
        default: begin
          tx_state <= CHC_TX_IDLE;
          tx_count <= 5'h00;
        end
      endcase
    end
  end

  // octet shifter, most significant octet first
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      tx_shift <= '0;
      tx_octet <= 8'h00;
      tx_octet_valid <= 1'b0;
      tx_octet_last <= 1'b0;
      tx_len_q <= 14'h0000;
    end else if (start_taken) begin
      tx_octet <= next_hdr[HDR_BITS-1 -: OCTET_BITS];
      tx_shift <= {next_hdr[HDR_BITS-OCTET_BITS-1:0], {OCTET_BITS{1'b0}}};
      tx_octet_valid <= 1'b1;
      tx_octet_last <= 1'b0;
      tx_len_q <= tx_req.payload_len;
    end else if (tx_state == CHC_TX_SEND && !tx_end) begin
      tx_octet <= tx_shift[HDR_BITS-1 -: OCTET_BITS];
      tx_shift <= {tx_shift[HDR_BITS-OCTET_BITS-1:0], {OCTET_BITS{1'b0}}};
      tx_octet_last <= tx_count == 5'(HDR_OCTETS - 5'h01);
    end else if (tx_end) begin
      tx_octet <= 8'h00;
      tx_octet_valid <= 1'b0;
      tx_octet_last <= 1'b0;
    end
  end

  // busy requests are dropped silently, illegal ones flagged
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      tx_ready <= 1'b1;
      tx_refused <= 1'b0;
    end else begin
      tx_refused <= tx_start && tx_state == CHC_TX_IDLE && !tx_ok;
      if (start_taken) begin
        tx_ready <= 1'b0;
      end else if (tx_end) begin
        tx_ready <= 1'b1;
      end
    end
  end

  // receive collection; a first marker always restarts
  assign rx_last = rx_octet_valid && !rx_octet_first && rx_state == CHC_RX_COLLECT &&
                   rx_count == 5'(HDR_OCTETS - 5'h01);
  assign rx_raw = chc_hdr_s'({rx_shift, rx_octet});

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      rx_state <= CHC_RX_IDLE;
      rx_count <= 5'h00;
      rx_shift <= '0;
    end else if (rx_octet_valid) begin
      if (rx_octet_first) begin
        rx_state <= CHC_RX_COLLECT;
        rx_count <= 5'h01;
        rx_shift <= {rx_shift[HDR_BITS-2*OCTET_BITS-1:0], rx_octet};
      end else if (rx_state == CHC_RX_COLLECT) begin
        rx_shift <= {rx_shift[HDR_BITS-2*OCTET_BITS-1:0], rx_octet};
        if (rx_last) begin
          rx_state <= CHC_RX_IDLE;
          rx_count <= 5'h00;
        end else begin
          rx_count <= 5'(rx_count + 5'h01);
        end
      end
    end
  end

  always_comb begin
    next_rx_hdr = '0;
    next_rx_err = '0;
    next_rx_hdr.dest = rx_dest_info;
    next_rx_hdr.src = rx_src_info;
    next_rx_hdr.destination_field = rx_raw.dest[VALUE_BITS-1:0];
    next_rx_hdr.origin_field = rx_raw.src[VALUE_BITS-1:0];
    next_rx_hdr.protocol_id = rx_raw.protocol_id;
    next_rx_hdr.pid_llc = rx_raw.protocol_id == PID_LLC;
    next_rx_hdr.pid_local = rx_raw.protocol_id >= PID_LOCAL_LO;
    next_rx_hdr.pad_count_field = rx_raw.pad_count_field;
    next_rx_hdr.access_urgency_field = rx_raw.access_urgency_field;
    next_rx_hdr.discard_pref_bit = rx_raw.discard_pref_bit;
    next_rx_hdr.checksum_present_bit = rx_raw.checksum_present_bit;
    next_rx_hdr.extension_size_field = rx_raw.extension_size_field;
    next_rx_hdr.ext_octets = {rx_raw.extension_size_field, 2'b00};
    next_rx_hdr.check_octets = rx_raw.checksum_present_bit ? CRC_OCTETS : 3'h0;
    next_rx_err.src_group = rx_src_info.group;
    next_rx_err.fmt_reserved = rx_dest_info.reserved || rx_src_info.reserved;
    next_rx_err.fmt_mismatch = rx_dest_info.fmt[3:2] != rx_src_info.fmt[3:2] ||
                               (rx_dest_info.fmt[3:2] != FMT_60_PREFIX && rx_dest_info.fmt != rx_src_info.fmt);
    next_rx_err.pid_reserved = !next_rx_hdr.pid_llc && !next_rx_hdr.pid_local;
    next_rx_err.ext_invalid = rx_raw.extension_size_field > EXT_MAX;
  end

  // results held until the next header completes
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      rx_hdr <= '0;
      rx_err <= '0;
      rx_done <= 1'b0;
    end else begin
      rx_done <= rx_last;
      if (rx_last) begin
        rx_hdr <= next_rx_hdr;
        rx_err <= next_rx_err;
      end
    end
  end

  sequence s_tx_body;
    (tx_octet_valid && !tx_octet_last) [*8];
  endsequence

  sequence s_tx_tail;
    (tx_octet_valid && tx_octet_last) ##1 (!tx_octet_valid && tx_ready);
  endsequence

  a_tx_frame_len: assert property (@(posedge sys_clk) disable iff (!resetn)
    start_taken |=> s_tx_body ##1 s_tx_body ##1 (tx_octet_valid && !tx_octet_last) [*3] ##1 s_tx_tail)
    else $error("header length not twenty octets");

  a_tx_dest_fmt: assert property (@(posedge sys_clk) disable iff (!resetn)
    start_taken |=> tx_octet[7:4] == $past(tx_req.dest_fmt) && !tx_ready)
    else $error("destination format code wrong");

  // origin format follows destination, group bit clear
  a_tx_origin_fmt: assert property (@(posedge sys_clk) disable iff (!resetn)
    tx_octet_valid && tx_count == OCT_SRC_FIRST |->
      tx_octet[7:6] == $past(tx_octet[7:6], 8) && tx_octet[4] == $past(tx_octet[4], 8) && !tx_octet[5])
    else $error("origin format or group bit wrong");

  a_tx_pad_align: assert property (@(posedge sys_clk) disable iff (!resetn)
    tx_octet_valid && tx_count == OCT_PIPL |-> 2'(tx_len_q[1:0] + tx_octet[1:0]) == 2'b00)
    else $error("pad count does not align payload");

  a_tx_quality_oct: assert property (@(posedge sys_clk) disable iff (!resetn)
    tx_octet_valid && tx_count == OCT_QCE |-> !tx_octet[4] && tx_octet[2:0] <= EXT_MAX)
    else $error("discard bit set or extension size invalid");

  a_tx_bridging_zero: assert property (@(posedge sys_clk) disable iff (!resetn)
    tx_octet_valid && tx_count >= OCT_BRIDGE |-> tx_octet == 8'h00)
    else $error("bridging octet not zero");

  sequence s_rx_run;
    (rx_octet_valid && !rx_octet_first) [*8];
  endsequence

  a_rx_done_time: assert property (@(posedge sys_clk) disable iff (!resetn)
    (rx_octet_valid && rx_octet_first) ##1 s_rx_run ##1 s_rx_run ##1 (rx_octet_valid && !rx_octet_first) [*3]
      |=> rx_done)
    else $error("header done at wrong octet");

  a_rx_broadcast: assert property (@(posedge sys_clk) disable iff (!resetn)
    rx_done |-> (!rx_hdr.dest.broadcast || rx_hdr.dest.group) && rx_hdr.src.group == rx_err.src_group)
    else $error("broadcast without group bit");

  a_rx_ext_check: assert property (@(posedge sys_clk) disable iff (!resetn)
    rx_done |-> rx_err.ext_invalid == (rx_hdr.ext_octets > 5'h14) &&
      rx_hdr.check_octets == (rx_hdr.checksum_present_bit ? CRC_OCTETS : 3'h0))
    else $error("extension or check length decode wrong");

  a_tx_refuse_pulse: assert property (@(posedge sys_clk) disable iff (!resetn)
    tx_start && tx_ready && tx_req.extension_size > EXT_MAX |=> tx_refused && !tx_octet_valid)
    else $error("illegal start not refused");

  a_tx_quality_val: assert property (@(posedge sys_clk) disable iff (!resetn)
    start_taken |-> ##18 tx_octet == {$past(tx_req.priority_level, 18), 1'b0,
      $past(tx_req.checksum_present, 18), $past(tx_req.extension_size, 18)})
    else $error("quality octet does not follow request");

  a_rx_result_hold: assert property (@(posedge sys_clk) disable iff (!resetn)
    !rx_done |-> $stable(rx_hdr) && $stable(rx_err))
    else $error("decoded header changed without done");

  a_tx_idle_zero: assert property (@(posedge sys_clk) disable iff (!resetn)
    !tx_octet_valid |-> tx_octet == 8'h00 && !tx_octet_last)
    else $error("octet lane not zero while idle");

endmodule : chc_header_codec
`default_nettype wire

// File: verification/chc_peer_model.sv
`timescale 1ns/1ps
`default_nettype none
module chc_peer_model (
  input wire logic sys_clk,
  output logic [7:0] rx_octet,
  output logic rx_octet_valid,
  output logic rx_octet_first
);
  initial begin
    rx_octet = 8'h00;
    rx_octet_valid = 1'b0;
    rx_octet_first = 1'b0;
  end

  // field order, one octet then gap idle clocks
  task automatic send(input logic [159:0] h, input int n, input int gap, input bit mark);
    for (int i = 0; i < n; i++) begin
      rx_octet <= h[159-8*i -: 8];
      rx_octet_valid <= 1'b1;
      rx_octet_first <= mark && (i == 0);
      @(posedge sys_clk);
      // idle line keeps changing so a stale octet cannot pass
      for (int g = 0; g < gap; g++) begin
        rx_octet <= ~h[159-8*i -: 8] ^ 8'(g);
        rx_octet_valid <= 1'b0;
        rx_octet_first <= 1'b0;
        @(posedge sys_clk);
      end
    end
    rx_octet <= ~h[159-8*(n-1) -: 8];
    rx_octet_valid <= 1'b0;
    rx_octet_first <= 1'b0;
    @(posedge sys_clk);
  endtask : send
endmodule : chc_peer_model
`default_nettype wire

// File: verification/chc_header_codec_tb.sv
`timescale 1ns/1ps
`default_nettype none
module chc_header_codec_tb import chc_pkg::*;;
  logic sys_clk, resetn, tx_start, tx_ready, tx_refused, tx_octet_valid, tx_octet_last;
  logic rx_octet_valid, rx_octet_first, rx_done;
  logic [7:0] tx_octet, rx_octet;
  chc_tx_req_s tx_req, r;
  chc_rx_hdr_s rx_hdr, mh;
  chc_rx_err_s rx_err, me;
  int err_count, n_compared, n_ref, seed, k;
  logic [191:0] rv;
  logic [8:0] tx_q[$];
  chc_rx_hdr_s hq[$];
  chc_rx_err_s eq[$];
  bit fq[$];
  logic [3:0] fmts[8] = '{4'h4, 4'h8, 4'hC, 4'hD, 4'hE, 4'hF, 4'hC, 4'h8};

  chc_header_codec i_dut (.sys_clk(sys_clk), .resetn(resetn), .tx_start(tx_start), .tx_req(tx_req),
    .tx_ready(tx_ready), .tx_refused(tx_refused), .tx_octet(tx_octet), .tx_octet_valid(tx_octet_valid),
    .tx_octet_last(tx_octet_last), .rx_octet(rx_octet), .rx_octet_valid(rx_octet_valid),
    .rx_octet_first(rx_octet_first), .rx_hdr(rx_hdr), .rx_err(rx_err), .rx_done(rx_done));
  chc_peer_model i_peer (.sys_clk(sys_clk), .rx_octet(rx_octet), .rx_octet_valid(rx_octet_valid),
    .rx_octet_first(rx_octet_first));

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : final_report

  task automatic chk(input string name, input logic [191:0] exp, input logic [191:0] got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  function automatic logic [63:0] mk_addr(logic [3:0] f, logic [59:0] v, logic [3:0] dg, logic ind);
    logic [59:0] s;
    int n;
    n = (dg == 4'h0) ? 15 : int'(dg);
    s = v;
    // digits to the top, ones fill
    if (f == FMT_60_PUB_IND) s = (v << (4 * (15 - n))) | ((60'h1 << (4 * (15 - n))) - 60'h1);
    if (f == FMT_16) s = {44'h0, v[15] & !ind, v[14:0]};
    if (f == FMT_48) s = {12'h0, v[47] & !ind, v[46:0]};
    return {f, s};
  endfunction : mk_addr

  function automatic logic [159:0] mk_hdr(chc_tx_req_s q);
    logic [3:0] sf;
    logic [1:0] pad;
    sf = (q.dest_fmt[3:2] == 2'h3) ? (q.dest_fmt & 4'hD) : q.dest_fmt;
    pad = 2'(3 - ((int'(q.payload_len) + 3) % 4));
    return {mk_addr(q.dest_fmt, q.dest_value, q.dest_digits, 1'b0), mk_addr(sf, q.src_value, q.src_digits, 1'b1),
      q.protocol_id, pad, q.priority_level, 1'b0, q.checksum_present, q.extension_size, 16'h0000};
  endfunction : mk_hdr

  function automatic chc_addr_info_s inf(logic [63:0] a);
    chc_addr_info_s i;
    i = '0;
    i.fmt = a[63:60];
    i.reserved = fmt_is_reserved(a[63:60]) ? 1'b1 : 1'b0;
    if (a[63:60] == FMT_16) begin
      i = '{a[63:60], a[15], &a[15:0], 1'b1, 1'b0};
    end
    if (a[63:60] == FMT_48) begin
      i = '{a[63:60], a[47], &a[47:0], a[46], 1'b0};
    end
    if (a[63:62] == 2'h3) i.group = a[61];
    return i;
  endfunction : inf

  function automatic int wcls(logic [3:0] f);
    return (f == FMT_16) ? 1 : (f == FMT_48) ? 2 : (f[3:2] == 2'h3) ? 3 : 0;
  endfunction : wcls

  task automatic tx_send(input chc_tx_req_s q, input bit ok);
    logic [159:0] h;
    h = mk_hdr(q);
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (tx_ready !== 1'b1 && k < 100);
    if (k >= 100) begin
      err_count++;
      final_report();
    end
    tx_req <= q;
    tx_start <= 1'b1;
    for (int i = 0; i < 20 && ok; i++) tx_q.push_back({i == 19, h[159-8*i -: 8]});
    @(posedge sys_clk);
    tx_start <= 1'b0;
  endtask : tx_send

  task automatic rx_case(input logic [63:0] d, input logic [63:0] s, input logic [5:0] pid,
      input logic [7:0] q, input int gap);
    chc_rx_hdr_s h;
    chc_rx_err_s e;
    h = '{inf(d), inf(s), d[59:0], s[59:0], pid, pid == PID_LLC, pid >= PID_LOCAL_LO, 2'h2, q[7:5], q[4],
      q[3], q[2:0], {q[2:0], 2'b00}, q[3] ? CRC_OCTETS : 3'h0};
    e = '{h.src.group, h.dest.reserved | h.src.reserved, wcls(d[63:60]) != wcls(s[63:60]),
      pid != PID_LLC && pid < PID_LOCAL_LO, q[2:0] > EXT_MAX};
    hq.push_back(h);
    eq.push_back(e);
    fq.push_back(!e.fmt_reserved);
    i_peer.send({d, s, pid, 2'h2, q, 16'h5A5A}, 20, gap, 1'b1);
  endtask : rx_case

  task automatic settle();
    for (k = 0; k < 400 && (tx_q.size() > 0 || hq.size() > 0); k++) @(posedge sys_clk);
    if (k >= 400) begin
      err_count++;
      $display("CHECK FAILED queues drained expected 0 seen %0d", tx_q.size() + hq.size());
      final_report();
    end
  endtask : settle

  always @(negedge sys_clk) begin
    if (resetn === 1'b1) begin
      if (tx_refused === 1'b1) n_ref++;
      if (tx_octet_valid === 1'b1) begin
        if (tx_q.size() == 0) chk("tx_q pending", 1, 0);
        else chk("tx_octet", tx_q.pop_front(), {tx_octet_last, tx_octet});
      end else chk("tx idle", 0, {tx_octet_last, tx_octet});
      if (rx_done === 1'b1) begin
        if (hq.size() == 0) chk("rx_q pending", 1, 0);
        else begin
          mh = hq.pop_front();
          me = eq.pop_front();
          if (fq.pop_front()) begin
            chk("rx_hdr", mh, rx_hdr);
            chk("rx_err", me, rx_err);
          end else chk("rx_err fmt", {me.fmt_reserved, me.ext_invalid}, {rx_err.fmt_reserved, rx_err.ext_invalid});
        end
      end
    end
  end

  initial begin
    #(50 * 20000);
    err_count++;
    final_report();
  end

  initial begin
    seed = 52;
    err_count = 0;
    n_compared = 0;
    n_ref = 0;
    resetn = 1'b0;
    tx_start = 1'b0;
    tx_req = '0;
    repeat (3) @(posedge sys_clk);
    resetn <= 1'b1;
    @(negedge sys_clk);
    chk("reset tx", {1'b1, 11'h0}, {tx_ready, tx_refused, tx_octet_valid, tx_octet_last, tx_octet});
    chk("reset outputs", 168'h0, {rx_hdr, rx_err, rx_done});
    for (int i = 0; i < 8; i++) begin
      rv = {$random(seed), $random(seed), $random(seed), $random(seed), $random(seed), $random(seed)};
      r = rv[$bits(chc_tx_req_s)-1:0];
      r.dest_fmt = fmts[i];
      r.priority_level = 3'(i);
      r.extension_size = 3'(i % 6);
      tx_send(r, 1'b1);
    end
    // a start while busy is dropped
    repeat (2) @(posedge sys_clk);
    tx_start <= 1'b1;
    @(posedge sys_clk);
    tx_start <= 1'b0;
    settle();
    $display("test transmit done");
    r.dest_fmt = 4'h0;
    tx_send(r, 1'b0);
    r.dest_fmt = FMT_48;
    r.extension_size = 3'h6;
    tx_send(r, 1'b0);
    r.extension_size = 3'h7;
    tx_send(r, 1'b0);
    repeat (3) @(posedge sys_clk);
    chk("tx_refused count", 3, n_ref);
    settle();
    $display("test refusal done");
    rv = {$random(seed), $random(seed), $random(seed), $random(seed), $random(seed), $random(seed)};
    rx_case({FMT_16, 44'h0, 16'hFFFF}, {FMT_16, 44'h0, 1'b0, rv[14:0]}, PID_LLC, 8'hED, 0);
    rx_case({FMT_48, 12'h0, 48'hFFFF_FFFF_FFFF}, {FMT_48, 12'h0, 2'b10, rv[45:0]}, 6'h30, 8'h00, 2);
    rx_case({4'hE, rv[59:0]}, {FMT_48, 12'h0, 2'b01, rv[91:46]}, 6'h02, 8'h16, 1);
    rx_case({4'hF, rv[119:60]}, {4'hD, rv[179:120]}, 6'h3F, 8'h48, 0);
    rx_case({4'h0, rv[59:0]}, {4'h0, rv[119:60]}, PID_LLC, 8'h07, 0);
    i_peer.send({FMT_48, rv[123:0], 32'h0}, 3, 0, 1'b0);
    i_peer.send({FMT_48, rv[123:0], 32'h0}, 7, 1, 1'b1);
    rx_case({FMT_48, 12'h0, 1'b0, rv[46:0]}, {FMT_48, 12'h0, 1'b0, rv[94:48]}, PID_LLC, 8'h2B, 0);
    settle();
    $display("test receive done");
    final_report();
  end
endmodule : chc_header_codec_tb
`default_nettype wire
